// [src/gph_pkg.sv]
// constants and carrier types for the 24-pin hot key gpio port
//
// Overview of operation
// - each 24-bit group spans three bytes: low 7:0, centre 15:8, high 23:16
// - pin monitor read returns present pin levels; writes are ignored
// - writing one to set-level drives that pin high; zero leaves it
// - writing one to clear-level drives that pin low; zero leaves it
// - direction zero makes a pin input, one makes it output
// - detected enabled edge sets the pin's edge status, sticky until cleared
// - writing one to edge status clears it; zero leaves it unchanged
// - rising-edge enable one enables low-to-high detection
// - falling-edge enable one enables high-to-low detection
// - pull-up bit one switches on the pin pull-up
// - pull-down bit one switches on the pin pull-down
// - two-bit function code: 00 primary, 01/10/11 alternate one to three
// - input hot key sets its pin flag on enabled edge, awake or asleep; irq when awake, wake when asleep
// - hot key during sleep wakes device, then interrupt is issued
// - hot key needs gpio input mode, global mask and per-pin mask enabled
// - hot key pulses of 62.5us or longer are always registered
// - writing one to a pin interrupt flag clears it; zero no effect
// - gpio interrupt raises the controller source flag; host reads per-pin flags
package gph_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned GPH_PINS = 24;

  // ---------------------------------------------------------------
  // register byte addresses (msb byte; csb +1, lsb +2)
  // ---------------------------------------------------------------
  localparam logic [7:0] GPH_ADDR_MONITOR = 8'ha2;
  localparam logic [7:0] GPH_ADDR_SET = 8'h83;
  localparam logic [7:0] GPH_ADDR_CLEAR = 8'h86;
  localparam logic [7:0] GPH_ADDR_DIR = 8'h89;
  localparam logic [7:0] GPH_ADDR_EDGE = 8'h8c;
  localparam logic [7:0] GPH_ADDR_RISE = 8'h8f;
  localparam logic [7:0] GPH_ADDR_FALL = 8'h92;
  localparam logic [7:0] GPH_ADDR_PULLUP = 8'h95;
  localparam logic [7:0] GPH_ADDR_PULLDOWN = 8'h98;
  localparam logic [7:0] GPH_ADDR_FSEL_UPPER = 8'h9b;
  localparam logic [7:0] GPH_ADDR_FSEL_LOWER = 8'h9e;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] GPH_RST_LEVEL = 24'h000000;
  localparam logic [23:0] GPH_RST_DIR = 24'h000000;
  localparam logic [23:0] GPH_RST_EDGE_EN = 24'h000000;
  localparam logic [23:0] GPH_RST_PULL = 24'h000000;
  localparam logic [23:0] GPH_RST_FSEL = 24'h000000;
  localparam logic [23:0] GPH_RST_STATUS = 24'h000000;
  localparam logic [7:0] GPH_RST_RDATA = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned GPH_CLK_PERIOD_NS = 10;
  localparam int unsigned GPH_MIN_PULSE_NS = 62500;
  // two samples inside the shortest pulse, rounded down
  localparam int unsigned GPH_SAMPLE_CYC = (GPH_MIN_PULSE_NS / 2) / GPH_CLK_PERIOD_NS;
  localparam int unsigned GPH_DIV_W = 12;
  localparam logic [GPH_DIV_W-1:0] GPH_RST_DIV = 12'h000;

  // ---------------------------------------------------------------
  // function codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GPH_FN_PRIMARY = 2'b00,
    GPH_FN_ALT1 = 2'b01,
    GPH_FN_ALT2 = 2'b10,
    GPH_FN_ALT3 = 2'b11
  } gph_fn_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gph_bus_req_t;

  typedef struct packed {
    logic global_en;
    logic sleep;
    logic [23:0] pin_mask;
    logic [23:0] flag_clear;
  } gph_irq_ctl_t;

  typedef struct packed {
    logic irq;
    logic wake;
    logic source_flag;
    logic [23:0] pin_flags;
  } gph_irq_stat_t;

endpackage

// [src/gph_pin_sync.sv]
// two-stage pin synchroniser with sampled edge detection
module gph_pin_sync
  import gph_pkg::*;
#(
  parameter int unsigned WIDTH = GPH_PINS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sampling strobe and pins
  input wire logic sample_i,
  input wire logic [WIDTH-1:0] pins_i,
  // synchronised level and edge pulses
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic armed;
  } gph_sync_state_t;

  gph_sync_state_t state_ff;
  gph_sync_state_t nxt_state;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.meta = pins_i;
    nxt_state.sync = state_ff.meta;
    // sample strobe
    // track the level until the first sample so reset gives no false edge
    if (sample_i || !state_ff.armed) begin
      nxt_state.last = state_ff.sync;
    end
    if (sample_i) begin
      nxt_state.armed = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign level_o = state_ff.last;
  assign rise_o = {WIDTH{sample_i & state_ff.armed}} & state_ff.sync & ~state_ff.last;
  assign fall_o = {WIDTH{sample_i & state_ff.armed}} & ~state_ff.sync & state_ff.last;

endmodule

// [src/gph_gpio_port.sv]
// 24-pin gpio port with byte registers, edge detect and hot key interrupt
module gph_gpio_port
  import gph_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = GPH_SAMPLE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte register port
  input wire gph_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // pins
  input wire logic [23:0] pin_in_i,
  output logic [23:0] pin_out_o,
  output logic [23:0] pin_oe_o,
  output logic [23:0] pull_up_o,
  output logic [23:0] pull_down_o,
  output logic [47:0] pin_function_code_o,
  // interrupt controller side
  input wire gph_irq_ctl_t irq_ctl_i,
  output gph_irq_stat_t irq_stat_o
);

  typedef struct packed {
    logic [23:0] out_level;
    logic [23:0] dir;
    logic [23:0] edge_st;
    logic [23:0] rise_en;
    logic [23:0] fall_en;
    logic [23:0] pull_up;
    logic [23:0] pull_down;
    logic [23:0] fsel_upper;
    logic [23:0] fsel_lower;
    logic [23:0] irq_flags;
    logic [GPH_DIV_W-1:0] div;
    logic [7:0] rdata;
  } gph_port_state_t;

  localparam logic [GPH_DIV_W-1:0] DIV_LAST = GPH_DIV_W'(SAMPLE_CYC - 1);

  gph_port_state_t state_ff;
  gph_port_state_t nxt_state;

  logic sample;
  logic [23:0] level;
  logic [23:0] rise;
  logic [23:0] fall;
  logic [23:0] gpio_mode;
  logic [23:0] edge_hit;
  logic [23:0] hot_hit;
  logic [47:0] fcodes;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // byte lanes hit by an address within a three-byte group
  function automatic logic [23:0] lane_mask(input logic [7:0] addr, input logic [7:0] base);
    logic [23:0] m;
    m = 24'h000000;
    if (addr == base) begin
      m = 24'hff0000;
    end else if (addr == base + 8'h01) begin
      m = 24'h00ff00;
    end else if (addr == base + 8'h02) begin
      m = 24'h0000ff;
    end
    return m;
  endfunction

  // replace the addressed byte of a group
  function automatic logic [23:0] put_byte(input logic [23:0] old, input logic [23:0] m,
                                           input logic [7:0] d);
    return (old & ~m) | ({d, d, d} & m);
  endfunction

  // pick the addressed byte of a group
  function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [23:0] m);
    logic [23:0] s;
    s = v & m;
    return s[23:16] | s[15:8] | s[7:0];
  endfunction

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  assign sample = (state_ff.div == DIV_LAST);

  gph_pin_sync #(
    .WIDTH(GPH_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(sample),
    .pins_i(pin_in_i),
    .level_o(level),
    .rise_o(rise),
    .fall_o(fall)
  );

  // ---------------------------------------------------------------
  // function codes and gpio mode
  // ---------------------------------------------------------------
  // upper holds pins 23..12, lower pins 11..0
  assign fcodes = {state_ff.fsel_upper, state_ff.fsel_lower};

  for (genvar p = 0; p < GPH_PINS; p++) begin : g_mode
    assign gpio_mode[p] = (gph_fn_t'(fcodes[2*p +: 2]) == GPH_FN_PRIMARY);
  end

  // ---------------------------------------------------------------
  // edge and hot key qualification
  // ---------------------------------------------------------------
  // edge enables
  assign edge_hit = (rise & state_ff.rise_en) | (fall & state_ff.fall_en);
  // gpio input, global and pin mask
  assign hot_hit = edge_hit & gpio_mode & ~state_ff.dir & irq_ctl_i.pin_mask
                 & {24{irq_ctl_i.global_en}};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [23:0] m;
    logic [23:0] edge_clr;
    m = 24'h000000;
    edge_clr = 24'h000000;
    nxt_state = state_ff;

    nxt_state.div = sample ? GPH_RST_DIV : state_ff.div + GPH_DIV_W'(1);

    if (bus_i.wr) begin
      m = lane_mask(bus_i.addr, GPH_ADDR_SET);
      nxt_state.out_level = state_ff.out_level | ({3{bus_i.wdata}} & m);
      m = lane_mask(bus_i.addr, GPH_ADDR_CLEAR);
      nxt_state.out_level = nxt_state.out_level & ~({3{bus_i.wdata}} & m);
      nxt_state.dir = put_byte(state_ff.dir, lane_mask(bus_i.addr, GPH_ADDR_DIR),
                               bus_i.wdata);
      nxt_state.rise_en = put_byte(state_ff.rise_en, lane_mask(bus_i.addr, GPH_ADDR_RISE),
                                   bus_i.wdata);
      nxt_state.fall_en = put_byte(state_ff.fall_en, lane_mask(bus_i.addr, GPH_ADDR_FALL),
                                   bus_i.wdata);
      nxt_state.pull_up = put_byte(state_ff.pull_up,
                                   lane_mask(bus_i.addr, GPH_ADDR_PULLUP), bus_i.wdata);
      nxt_state.pull_down = put_byte(state_ff.pull_down,
                                     lane_mask(bus_i.addr, GPH_ADDR_PULLDOWN), bus_i.wdata);
      nxt_state.fsel_upper = put_byte(state_ff.fsel_upper,
                                      lane_mask(bus_i.addr, GPH_ADDR_FSEL_UPPER), bus_i.wdata);
      nxt_state.fsel_lower = put_byte(state_ff.fsel_lower,
                                      lane_mask(bus_i.addr, GPH_ADDR_FSEL_LOWER), bus_i.wdata);
      edge_clr = {3{bus_i.wdata}} & lane_mask(bus_i.addr, GPH_ADDR_EDGE);
    end

    nxt_state.edge_st = (state_ff.edge_st & ~edge_clr) | edge_hit;
    // pin flags clear on one, set wins
    nxt_state.irq_flags = (state_ff.irq_flags & ~irq_ctl_i.flag_clear) | hot_hit;

    if (bus_i.rd) begin
      m = lane_mask(bus_i.addr, GPH_ADDR_MONITOR);
      nxt_state.rdata = get_byte(level, m)
                      | get_byte(state_ff.dir, lane_mask(bus_i.addr, GPH_ADDR_DIR))
                      | get_byte(state_ff.edge_st, lane_mask(bus_i.addr, GPH_ADDR_EDGE))
                      | get_byte(state_ff.rise_en, lane_mask(bus_i.addr, GPH_ADDR_RISE))
                      | get_byte(state_ff.fall_en, lane_mask(bus_i.addr, GPH_ADDR_FALL))
                      | get_byte(state_ff.pull_up, lane_mask(bus_i.addr, GPH_ADDR_PULLUP))
                      | get_byte(state_ff.pull_down,
                                 lane_mask(bus_i.addr, GPH_ADDR_PULLDOWN))
                      | get_byte(state_ff.fsel_upper,
                                 lane_mask(bus_i.addr, GPH_ADDR_FSEL_UPPER))
                      | get_byte(state_ff.fsel_lower,
                                 lane_mask(bus_i.addr, GPH_ADDR_FSEL_LOWER));
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff.out_level <= GPH_RST_LEVEL;
      state_ff.dir <= GPH_RST_DIR;
      state_ff.edge_st <= GPH_RST_STATUS;
      state_ff.rise_en <= GPH_RST_EDGE_EN;
      state_ff.fall_en <= GPH_RST_EDGE_EN;
      state_ff.pull_up <= GPH_RST_PULL;
      state_ff.pull_down <= GPH_RST_PULL;
      state_ff.fsel_upper <= GPH_RST_FSEL;
      state_ff.fsel_lower <= GPH_RST_FSEL;
      state_ff.irq_flags <= GPH_RST_STATUS;
      state_ff.div <= GPH_RST_DIV;
      state_ff.rdata <= GPH_RST_RDATA;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o = state_ff.rdata;
  assign pin_out_o = state_ff.out_level;
  assign pin_oe_o = state_ff.dir;
  assign pull_up_o = state_ff.pull_up;
  assign pull_down_o = state_ff.pull_down;
  assign pin_function_code_o = fcodes;
  assign irq_stat_o.pin_flags = state_ff.irq_flags;
  assign irq_stat_o.source_flag = |state_ff.irq_flags;
  assign irq_stat_o.wake = (|state_ff.irq_flags) & irq_ctl_i.sleep;
  assign irq_stat_o.irq = (|state_ff.irq_flags) & ~irq_ctl_i.sleep;

endmodule

// [testbench/gph_gpio_port_assertions.sv]
// port assertions for the gpio port
module gph_port_checker
  import gph_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = GPH_SAMPLE_CYC
) (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gph_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  // pins
  input wire logic [23:0] pin_in_i,
  input wire logic [23:0] pin_out_o,
  input wire logic [23:0] pin_oe_o,
  input wire logic [47:0] pin_function_code_o,
  // interrupt side
  input wire gph_irq_ctl_t irq_ctl_i,
  input wire gph_irq_stat_t irq_stat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [23:0] last_pin_ff;
  logic [15:0] calm_ff;
  // cycles since any pin last moved
  always_ff @(posedge clk_i) begin
    last_pin_ff <= pin_in_i;
    if (rst_i || pin_in_i != last_pin_ff) calm_ff <= 16'h0000;
    else if (calm_ff != 16'hffff) calm_ff <= calm_ff + 16'h0001;
  end
  a_set_level_high: assert property (
    bus_i.wr && bus_i.addr == GPH_ADDR_SET + 8'h02 |=>
    (pin_out_o[7:0] & $past(bus_i.wdata)) == $past(bus_i.wdata)) else $error("set lost");
  a_clear_level_low: assert property (
    bus_i.wr && bus_i.addr == GPH_ADDR_CLEAR |=>
    (pin_out_o[23:16] & $past(bus_i.wdata)) == 8'h00) else $error("clear lost");
  a_dir_centre_byte: assert property (
    bus_i.wr && bus_i.addr == GPH_ADDR_DIR + 8'h01 |=>
    pin_oe_o[15:8] == $past(bus_i.wdata)) else $error("direction byte wrong");
  a_fsel_upper_map: assert property (
    bus_i.wr && bus_i.addr == GPH_ADDR_FSEL_UPPER |=>
    pin_function_code_o[47:40] == $past(bus_i.wdata)) else $error("upper codes wrong");
  a_dir_read_back: assert property (
    bus_i.rd && bus_i.addr == GPH_ADDR_DIR + 8'h02 |=>
    rdata_o == $past(pin_oe_o[7:0])) else $error("direction read wrong");
  a_monitor_level: assert property (
    bus_i.rd && bus_i.addr == GPH_ADDR_MONITOR + 8'h02 && calm_ff > SAMPLE_CYC + 4 |=>
    rdata_o == $past(pin_in_i[7:0])) else $error("monitor wrong");
  a_flag_sticky: assert property (
    $fell(irq_stat_o.pin_flags[0]) |-> $past(irq_ctl_i.flag_clear[0]))
    else $error("flag dropped");
  a_flag_needs_mask: assert property (
    $rose(irq_stat_o.pin_flags[0]) |-> $past(irq_ctl_i.global_en && irq_ctl_i.pin_mask[0]
    && !pin_oe_o[0] && pin_function_code_o[1:0] == 2'b00)) else $error("unmasked flag");
  a_sleep_no_irq: assert property (
    irq_ctl_i.sleep && $past(irq_ctl_i.sleep) |-> !irq_stat_o.irq
    && irq_stat_o.wake == (|irq_stat_o.pin_flags))
    else $error("irq while asleep");
  a_source_or: assert property (
    irq_stat_o.source_flag == (|irq_stat_o.pin_flags)) else $error("source flag wrong");
endmodule

// [testbench/gph_pin_model.sv]
// keys, pulls and floating lines at the pins
module gph_pin_model (
  // clock
  input wire logic clk_i,
  // port side
  input wire logic [23:0] out_i,
  input wire logic [23:0] oe_i,
  input wire logic [23:0] pu_i,
  input wire logic [23:0] pd_i,
  // key side
  input wire logic [23:0] key_en_i,
  input wire logic [23:0] key_lvl_i,
  // resolved level
  output logic [23:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] float_ff = 24'h000000;
  always_ff @(posedge clk_i) float_ff <= ~float_ff;
  always_comb begin
    for (int p = 0; p < 24; p++) begin
      if (oe_i[p]) level_o[p] = out_i[p];
      else if (key_en_i[p]) level_o[p] = key_lvl_i[p];
      else if (pu_i[p]) level_o[p] = 1'b1;
      else if (pd_i[p]) level_o[p] = 1'b0;
      else level_o[p] = float_ff[p];
    end
  end
endmodule

// [testbench/gph_gpio_port_test.sv]
// testbench for the gpio port
module gph_gpio_port_test
  import gph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  gph_bus_req_t bus_req = '0;
  gph_irq_ctl_t irq_ctl = '0;
  gph_irq_stat_t irq_stat;
  logic [7:0] rdata;
  logic [23:0] pin_lvl, pin_out, pin_oe, pull_up, pull_down, v;
  logic [47:0] fn_code;
  logic [23:0] key_en = 24'hffffff;
  logic [23:0] key_lvl = 24'h000000;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] regs [11] = '{GPH_ADDR_MONITOR, GPH_ADDR_SET, GPH_ADDR_CLEAR, GPH_ADDR_DIR,
    GPH_ADDR_EDGE, GPH_ADDR_RISE, GPH_ADDR_FALL, GPH_ADDR_PULLUP, GPH_ADDR_PULLDOWN,
    GPH_ADDR_FSEL_UPPER, GPH_ADDR_FSEL_LOWER};
  always #5 clk_i = ~clk_i;
  gph_gpio_port #(.SAMPLE_CYC(SC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_req),
    .rdata_o(rdata), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .pull_up_o(pull_up), .pull_down_o(pull_down), .pin_function_code_o(fn_code),
    .irq_ctl_i(irq_ctl), .irq_stat_o(irq_stat));
  gph_pin_model u_pins (.clk_i(clk_i), .out_i(pin_out), .oe_i(pin_oe), .pu_i(pull_up),
    .pd_i(pull_down), .key_en_i(key_en), .key_lvl_i(key_lvl), .level_o(pin_lvl));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [23:0] pat(input int k);
    return 24'he4c3a5 ^ {3{k[7:0]}};
  endfunction
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    bus_req.wr = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    bus_req.rd = 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask
  task automatic wr24(input logic [7:0] a, input logic [23:0] d);
    wr(a, d[23:16]);
    wr(a + 8'h01, d[15:8]);
    wr(a + 8'h02, d[7:0]);
  endtask
  task automatic rd24(input logic [7:0] a, output logic [23:0] d);
    rd(a, d[23:16]);
    rd(a + 8'h01, d[15:8]);
    rd(a + 8'h02, d[7:0]);
  endtask
  task automatic settle();
    repeat (SC + 4) @(negedge clk_i);
  endtask
  task automatic pulse(input logic [23:0] m);
    key_lvl = m;
    repeat (2 * SC) @(negedge clk_i);
    key_lvl = 24'h000000;
    settle();
  endtask
  task automatic fclr(input logic [23:0] m);
    irq_ctl.flag_clear = m;
    @(negedge clk_i);
    irq_ctl.flag_clear = 24'h000000;
    @(negedge clk_i);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    for (int k = 0; k < 11; k++) begin
      rd24(regs[k], v);
      check("reset value", v, 24'h000000);
    end
    rd(8'ha6, v[7:0]);
    check("unmapped read", v[7:0], 8'h00);
    $display("test reset done");
    for (int k = 3; k < 11; k++) wr24(regs[k], pat(k));
    for (int k = 5; k < 11; k++) begin
      rd24(regs[k], v);
      check("read back", v, pat(k));
    end
    check("direction", pin_oe, pat(3));
    check("pull up", pull_up, pat(7));
    check("pull down", pull_down, pat(8));
    check("function codes", fn_code, {pat(9), pat(10)});
    for (int k = 3; k < 11; k++) wr24(regs[k], 24'h000000);
    $display("test registers done");
    wr(regs[10] + 8'h02, 8'he4);
    check("all codes", fn_code[7:0], 8'he4);
    wr(regs[1] + 8'h02, 8'h5a);
    wr(regs[1] + 8'h02, 8'h00);
    check("set level", pin_out[7:0], 8'h5a);
    wr(regs[2] + 8'h02, 8'h0a);
    wr(regs[2] + 8'h02, 8'h00);
    check("clear level", pin_out[7:0], 8'h50);
    wr(regs[1], 8'h81);
    wr(regs[2], 8'h80);
    check("high byte", pin_out, 24'h010050);
    wr(regs[3] + 8'h02, 8'hff);
    wr(regs[0] + 8'h02, 8'hff);
    settle();
    rd(regs[0] + 8'h02, v[7:0]);
    check("monitor", v[7:0], 8'h50);
    rd(regs[1] + 8'h02, v[7:0]);
    check("set reads zero", v[7:0], 8'h00);
    $display("test levels done");
    key_en = 24'hff00ff;
    wr(regs[7] + 8'h01, 8'hff);
    settle();
    rd(regs[0] + 8'h01, v[7:0]);
    check("pull up level", v[7:0], 8'hff);
    wr(regs[7] + 8'h01, 8'h00);
    wr(regs[8] + 8'h01, 8'hff);
    settle();
    rd(regs[0] + 8'h01, v[7:0]);
    check("pull down level", v[7:0], 8'h00);
    key_en = 24'hffffff;
    $display("test pulls done");
    wr(regs[10] + 8'h02, 8'h40);
    wr(regs[3] + 8'h02, 8'h00);
    settle();
    wr(regs[5] + 8'h02, 8'h0d);
    wr(regs[6] + 8'h02, 8'h02);
    wr(regs[4] + 8'h02, 8'hff);
    irq_ctl.global_en = 1'b1;
    irq_ctl.pin_mask = 24'h00000b;
    pulse(24'h00000f);
    rd(regs[4] + 8'h02, v[7:0]);
    check("edge status", v[7:0], 8'h0f);
    check("flags", {irq_stat.irq, irq_stat.pin_flags}, {1'b1, 24'h000003});
    wr(regs[4] + 8'h02, 8'h00);
    wr(regs[4] + 8'h02, 8'h05);
    rd(regs[4] + 8'h02, v[7:0]);
    check("edge clear", v[7:0], 8'h0a);
    fclr(24'h000001);
    check("flag clear", {irq_stat.source_flag, irq_stat.pin_flags}, {1'b1, 24'h2});
    irq_ctl.sleep = 1'b1;
    repeat (2) @(negedge clk_i);
    check("sleep wake", {irq_stat.irq, irq_stat.wake}, 2'b01);
    fclr(24'h000002);
    pulse(24'h000001);
    check("asleep key", {irq_stat.wake, irq_stat.pin_flags}, {1'b1, 24'h1});
    irq_ctl.sleep = 1'b0;
    @(negedge clk_i);
    check("awake irq", {irq_stat.irq, irq_stat.wake}, 2'b10);
    fclr(24'h000001);
    irq_ctl.global_en = 1'b0;
    pulse(24'h000001);
    check("global mask", irq_stat.pin_flags, 24'h000000);
    $display("test hot key done");
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    stop_test();
  end
endmodule
bind gph_gpio_port gph_port_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_function_code_o(pin_function_code_o),
  .irq_ctl_i(irq_ctl_i), .irq_stat_o(irq_stat_o));
